// >>> rtl/pgf_consts.svh
// Offsets, field positions, reset values and sizes of the pixel gain stage.
`ifndef PGF_CONSTS_SVH
`define PGF_CONSTS_SVH
`define PGF_A_CTRL     8'h00
`define PGF_A_CMD      8'h04
`define PGF_A_STAT     8'h08
`define PGF_A_TGT      8'h0C
`define PGF_CTRL_RST   8'h01
`define PGF_TGT_RST    8'hAF
`define PGF_B_GAIN_EN  0
`define PGF_B_MAP_EN   1
`define PGF_F_GSEL     3:2
`define PGF_F_MSEL     7:4
`define PGF_C_GGEN     0
`define PGF_C_GSAVE    1
`define PGF_C_GLOAD    2
`define PGF_C_MGEN     3
`define PGF_C_MSAVE    4
`define PGF_C_MLOAD    5
`define PGF_S_REFUSED  1
`define PGF_UNITY      8'h80
`define PGF_PIX_MAX    8'hFF
`define PGF_MAP_RST    8'hFF
`define PGF_XY_LAST    4'hF
`define PGF_GAIN_LAST  8'hFF
`define PGF_MAP_LAST   8'h18
`define PGF_FIFO_DEPTH 8
`define PGF_RESP_OK    2'h0
`define PGF_RESP_ERR   2'h2
`endif

// >>> rtl/pgf_pkg.sv
// Types shared by the pixel gain and flat-field correction stage.
`default_nettype none
package pgf_pkg;
   typedef enum logic [1:0] {S_IDLE, S_GWAIT, S_GRUN, S_COPY} pgf_state_e;
   typedef logic [7:0] pgf_pix_t;
endpackage
`default_nettype wire

// >>> rtl/pgf_top.sv
// Pixel gain and flat-field correction stage with its output FIFO.
// Functional notes
// R01: Gain slot 0 is factory data, loadable only; saves to it are refused.
// R02: Three user gain slots in non-volatile storage, each saved and loaded.
// R03: Gain generate computes a per-pixel gain table from the next frame.
// R04: A generated gain table is active at once and lives in working memory.
// R05: Working tables return to defaults on reset.
// R06: Gain save writes the working table over the selected user slot.
// R07: Gain load copies the selected slot into the working table.
// R08: Corrected level is the pixel level divided by the map level; the code multiplies the pixel level by the target before dividing.
// R09: Map generate samples the next frame; host must capture that frame.
// R10: Map save stores the working map in the selected map slot.
// R11: The coarse map is bilinearly expanded before dividing.
// R12: Map load replaces a generated map with a stored one.
// R13: The map acts only while the map enable is on.
// R14: Host runs dark-offset calibration before gain calibration.
// R15: Host turns map correction off before gain calibration.
// R16: Host runs free acquisition before gain generate.
// R17: Host sets calibration scene to levels 150 to 200 at unity gain.
// R18: Sixteen map slots, zero to fifteen, for save and load.
// R19: Division saturates at full scale; zero map level means maximum gain.
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`default_nettype none
`include "pgf_consts.svh"

module pgf_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_b,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0]    wp_q;
   logic [AW-1:0]    rp_q;
   logic [AW:0]      cnt_q;
   logic             wr;
   logic             rd;

   assign in_ready  = cnt_q != DEPTH[AW:0];
   assign out_valid = cnt_q != '0;
   assign out_data  = mem[rp_q];
   assign wr        = in_valid && in_ready;
   assign rd        = out_valid && out_ready;

   always_ff @(posedge sys_clk) begin
      if (wr) begin
         mem[wp_q] <= in_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (wr) begin
            wp_q <= wp_q + 1'b1;
         end
         if (rd) begin
            rp_q <= rp_q + 1'b1;
         end
         case ({wr, rd})
            2'b10:   cnt_q <= cnt_q + 1'b1;
            2'b01:   cnt_q <= cnt_q - 1'b1;
            default: cnt_q <= cnt_q;
         endcase
      end
   end
endmodule

module pgf_top (
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        pix_in_valid,
   output logic             pix_in_ready,
   input  wire logic [7:0]  pix_in_data,
   input  wire logic        pix_in_sof,
   output logic             pix_out_valid,
   input  wire logic        pix_out_ready,
   output logic [7:0]       pix_out_data,
   output logic             pix_out_sof
);
   pgf_pkg::pgf_pix_t   gain_tbl [0:255];
   pgf_pkg::pgf_pix_t   gain_nv  [0:767];
   pgf_pkg::pgf_pix_t   map_tbl  [0:24];
   pgf_pkg::pgf_pix_t   map_nv   [0:511];
   pgf_pkg::pgf_state_e st_q;
   logic                kind_q;
   logic                dir_q;
   logic [3:0]          slot_q;
   logic [7:0]          cnt_q;
   logic                aw_q;
   logic [7:0]          awa_q;
   logic                w_q;
   logic [31:0]         wd_q;
   logic [3:0]          ws_q;
   logic                do_wr;
   logic [7:0]          ctrl_q;
   logic [7:0]          tgt_q;
   logic                refused_q;
   logic                ref_set;
   logic                map_valid_q;
   logic [5:0]          cmd;
   logic [3:0]          x_q;
   logic [3:0]          y_q;
   logic [3:0]          px;
   logic [3:0]          py;
   logic [7:0]          gi;
   logic                in_fire;
   logic                gen_act;
   logic                last_px;
   logic [15:0]         gprod;
   pgf_pkg::pgf_pix_t   gout;
   pgf_pkg::pgf_pix_t   gnew;
   pgf_pkg::pgf_pix_t   na;
   pgf_pkg::pgf_pix_t   nb;
   pgf_pkg::pgf_pix_t   nc;
   pgf_pkg::pgf_pix_t   nd;
   logic [11:0]         wx0;
   logic [11:0]         wx1;
   logic [11:0]         wy0;
   logic [11:0]         wy1;
   logic [11:0]         isum;
   pgf_pkg::pgf_pix_t   interp;
   pgf_pkg::pgf_pix_t   corr;
   logic [2:0]          cx;
   logic [2:0]          cy;
   logic [2:0]          mc;
   logic [2:0]          mr;
   logic [9:0]          gidx;
   logic [8:0]          midx;
   pgf_pkg::pgf_pix_t   cp_g;
   pgf_pkg::pgf_pix_t   nv_g;

   function automatic pgf_pkg::pgf_pix_t div_sat(input logic [15:0] n, input logic [7:0] d);
      logic [15:0] q;
      q = 16'h0000;
      if (d == 8'h00) begin
         return `PGF_PIX_MAX;
      end
      q = n / {8'h00, d};
      return (q[15:8] != 8'h00) ? `PGF_PIX_MAX : q[7:0];
   endfunction

   function automatic logic [4:0] node_idx(input logic [2:0] c, input logic [2:0] r);
      return 5'({2'b00, r} * 5'h05) + {2'b00, c};
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      return (a[7:4] == 4'h0) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [31:0] reg_rd(input logic [7:0] a);
      if (a == `PGF_A_CTRL) begin
         return {24'h000000, ctrl_q};
      end else if (a == `PGF_A_STAT) begin
         return {29'h00000000, map_valid_q, refused_q, st_q != pgf_pkg::S_IDLE};
      end else if (a == `PGF_A_TGT) begin
         return {24'h000000, tgt_q};
      end else begin
         return 32'h00000000;
      end
   endfunction

   // Register slave; address and data may arrive in either order.
   assign awready = !aw_q;
   assign wready  = !w_q;
   assign arready = !rvalid;
   assign do_wr   = aw_q && w_q && !bvalid;
   assign cmd     = (do_wr && ws_q[0] && awa_q == `PGF_A_CMD) ? wd_q[5:0] : 6'h00;

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         aw_q   <= 1'b0;
         w_q    <= 1'b0;
         awa_q  <= 8'h00;
         wd_q   <= 32'h00000000;
         ws_q   <= 4'h0;
         bvalid <= 1'b0;
         bresp  <= `PGF_RESP_OK;
      end else begin
         if (awvalid && awready) begin
            aw_q  <= 1'b1;
            awa_q <= awaddr;
         end else if (do_wr) begin
            aw_q <= 1'b0;
         end
         if (wvalid && wready) begin
            w_q  <= 1'b1;
            wd_q <= wdata;
            ws_q <= wstrb;
         end else if (do_wr) begin
            w_q <= 1'b0;
         end
         if (do_wr) begin
            bvalid <= 1'b1;
            bresp  <= addr_ok(awa_q) ? `PGF_RESP_OK : `PGF_RESP_ERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         rvalid <= 1'b0;
         rdata  <= 32'h00000000;
         rresp  <= `PGF_RESP_OK;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata  <= reg_rd(araddr);
         rresp  <= addr_ok(araddr) ? `PGF_RESP_OK : `PGF_RESP_ERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         ctrl_q <= `PGF_CTRL_RST;
         tgt_q  <= `PGF_TGT_RST;
      end else if (do_wr && ws_q[0] && awa_q == `PGF_A_CTRL) begin
         ctrl_q <= wd_q[7:0];
      end else if (do_wr && ws_q[0] && awa_q == `PGF_A_TGT) begin
         tgt_q <= wd_q[7:0];
      end
   end

   // R01 factory slot refusal
   assign ref_set = st_q == pgf_pkg::S_IDLE && !cmd[`PGF_C_GGEN] && cmd[`PGF_C_GSAVE]
                    && ctrl_q[`PGF_F_GSEL] == 2'h0;

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         refused_q <= 1'b0;
      end else if (ref_set) begin
         refused_q <= 1'b1;
      end else if (do_wr && ws_q[0] && awa_q == `PGF_A_STAT && wd_q[`PGF_S_REFUSED]) begin
         refused_q <= 1'b0;
      end
   end

   // Command sequencing; commands arriving while busy are dropped.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         st_q   <= pgf_pkg::S_IDLE;
         kind_q <= 1'b0;
         dir_q  <= 1'b0;
         slot_q <= 4'h0;
         cnt_q  <= 8'h00;
      end else begin
         case (st_q)
            pgf_pkg::S_IDLE: begin
               cnt_q <= 8'h00;
               if (cmd[`PGF_C_GGEN]) begin
                  st_q   <= pgf_pkg::S_GWAIT;
                  kind_q <= 1'b0;
               end else if (cmd[`PGF_C_GSAVE] && !ref_set) begin
                  st_q   <= pgf_pkg::S_COPY;
                  {kind_q, dir_q} <= 2'b01;
                  slot_q <= {2'b00, ctrl_q[`PGF_F_GSEL]};
               end else if (cmd[`PGF_C_GLOAD]) begin
                  st_q   <= pgf_pkg::S_COPY;
                  {kind_q, dir_q} <= 2'b00;
                  slot_q <= {2'b00, ctrl_q[`PGF_F_GSEL]};
               end else if (cmd[`PGF_C_MGEN]) begin
                  st_q   <= pgf_pkg::S_GWAIT;
                  kind_q <= 1'b1;
               end else if (cmd[`PGF_C_MSAVE] || cmd[`PGF_C_MLOAD]) begin
                  st_q   <= pgf_pkg::S_COPY;
                  {kind_q, dir_q} <= {1'b1, cmd[`PGF_C_MSAVE]};
                  slot_q <= ctrl_q[`PGF_F_MSEL];
               end
            end
            // R09 sample exactly the next frame
            pgf_pkg::S_GWAIT: begin
               if (in_fire && pix_in_sof) begin
                  st_q <= pgf_pkg::S_GRUN;
               end
            end
            pgf_pkg::S_GRUN: begin
               if (in_fire && last_px) begin
                  st_q <= pgf_pkg::S_IDLE;
               end
            end
            pgf_pkg::S_COPY: begin
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q == (kind_q ? `PGF_MAP_LAST : `PGF_GAIN_LAST)) begin
                  st_q <= pgf_pkg::S_IDLE;
               end
            end
            default: st_q <= pgf_pkg::S_IDLE;
         endcase
      end
   end

   // Pixel position within the frame.
   assign in_fire = pix_in_valid && pix_in_ready;
   assign px      = pix_in_sof ? 4'h0 : x_q;
   assign py      = pix_in_sof ? 4'h0 : y_q;
   assign gi      = {py, px};
   assign last_px = px == `PGF_XY_LAST && py == `PGF_XY_LAST;
   assign gen_act = in_fire && (st_q == pgf_pkg::S_GRUN
                    || (st_q == pgf_pkg::S_GWAIT && pix_in_sof));

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         x_q <= 4'h0;
         y_q <= 4'h0;
      end else if (in_fire) begin
         x_q <= px + 4'h1;
         y_q <= (px == `PGF_XY_LAST) ? py + 4'h1 : py;
      end
   end

   // Gain stage, unity is 0x80.
   assign gprod = {8'h00, pix_in_data} * {8'h00, gain_tbl[gi]};
   assign gout  = !ctrl_q[`PGF_B_GAIN_EN] ? pix_in_data
                  : (gprod[15] ? `PGF_PIX_MAX : gprod[14:7]);
   // R03 gain from target over raw level
   assign gnew  = div_sat({1'b0, tgt_q, 7'h00}, pix_in_data);

   // R11 bilinear expansion of the 5x5 map
   assign cx   = {1'b0, px[3:2]};
   assign cy   = {1'b0, py[3:2]};
   assign na   = map_tbl[node_idx(cx, cy)];
   assign nb   = map_tbl[node_idx(cx + 3'h1, cy)];
   assign nc   = map_tbl[node_idx(cx, cy + 3'h1)];
   assign nd   = map_tbl[node_idx(cx + 3'h1, cy + 3'h1)];
   assign wx1  = {10'h000, px[1:0]};
   assign wy1  = {10'h000, py[1:0]};
   assign wx0  = 12'h004 - wx1;
   assign wy0  = 12'h004 - wy1;
   assign isum = wx0 * wy0 * {4'h0, na} + wx1 * wy0 * {4'h0, nb}
                 + wx0 * wy1 * {4'h0, nc} + wx1 * wy1 * {4'h0, nd};
   assign interp = isum[11:4];
   // R08 R13 R19 divide by map only when enabled
   assign corr = ctrl_q[`PGF_B_MAP_EN]
                 ? div_sat({8'h00, gout} * {8'h00, tgt_q}, interp) : gout;

   // Map nodes sit on every fourth pixel plus the last column and row.
   assign mc = (px == `PGF_XY_LAST) ? 3'h4 : cx;
   assign mr = (py == `PGF_XY_LAST) ? 3'h4 : cy;

   // R02 user slots 1..3 occupy the gain store
   assign gidx = {slot_q[1:0] - 2'h1, cnt_q};
   // R18 sixteen map slots
   assign midx = {slot_q, cnt_q[4:0]};
   assign cp_g = gain_tbl[cnt_q];
   assign nv_g = gain_nv[gidx];

   // R04 R05 R07 working gain table
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         for (int i = 0; i < 256; i++) begin
            gain_tbl[i] <= `PGF_UNITY;
         end
      end else if (gen_act && !kind_q) begin
         gain_tbl[gi] <= gnew;
      end else if (st_q == pgf_pkg::S_COPY && !kind_q && !dir_q) begin
         gain_tbl[cnt_q] <= (slot_q == 4'h0) ? `PGF_UNITY : nv_g;
      end
   end

   // R06 R10 saves to non-volatile slots
   always_ff @(posedge sys_clk) begin
      if (st_q == pgf_pkg::S_COPY && dir_q && !kind_q) begin
         gain_nv[gidx] <= cp_g;
      end
      if (st_q == pgf_pkg::S_COPY && dir_q && kind_q) begin
         map_nv[midx] <= map_tbl[cnt_q[4:0]];
      end
   end

   // R09 R12 working map capture and load
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         for (int i = 0; i < 25; i++) begin
            map_tbl[i] <= `PGF_MAP_RST;
         end
         map_valid_q <= 1'b0;
      end else if (gen_act && kind_q) begin
         if ((px[1:0] == 2'h0 || px == `PGF_XY_LAST) && (py[1:0] == 2'h0 || py == `PGF_XY_LAST)) begin
            map_tbl[node_idx(mc, mr)] <= pix_in_data;
         end
         if (last_px) begin
            map_valid_q <= 1'b1;
         end
      end else if (st_q == pgf_pkg::S_COPY && kind_q && !dir_q) begin
         map_tbl[cnt_q[4:0]] <= map_nv[midx];
         map_valid_q         <= 1'b1;
      end
   end

   pgf_fifo #(
      .WIDTH (9),
      .DEPTH (`PGF_FIFO_DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .rst_b     (rst_b),
      .in_valid  (pix_in_valid),
      .in_ready  (pix_in_ready),
      .in_data   ({pix_in_sof, corr}),
      .out_valid (pix_out_valid),
      .out_ready (pix_out_ready),
      .out_data  ({pix_out_sof, pix_out_data})
   );

   AST_FACTORY_REFUSE: assert property (@(posedge sys_clk) disable iff (!rst_b) // R01
      ref_set |=> refused_q && st_q == pgf_pkg::S_IDLE)
      else $error("factory save not refused");
   AST_USER_SAVE: assert property (@(posedge sys_clk) disable iff (!rst_b) // R06
      st_q == pgf_pkg::S_COPY && dir_q && !kind_q |=> gain_nv[$past(gidx)] == $past(cp_g))
      else $error("gain save wrong");
   AST_GEN_START: assert property (@(posedge sys_clk) disable iff (!rst_b) // R03
      st_q == pgf_pkg::S_IDLE && cmd[`PGF_C_GGEN] |=> st_q == pgf_pkg::S_GWAIT && !kind_q)
      else $error("gain generate not started");
   AST_GEN_ACTIVE: assert property (@(posedge sys_clk) disable iff (!rst_b) // R04
      gen_act && !kind_q |=> gain_tbl[$past(gi)] == $past(gnew))
      else $error("generated gain not active");
   AST_RESET_LOSS: assert property (@(posedge sys_clk) disable iff (!rst_b) // R05
      $rose(rst_b) |-> gain_tbl[5] == `PGF_UNITY && !map_valid_q && !pix_out_valid)
      else $error("working data kept over reset");
   AST_GAIN_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_b) // R07
      st_q == pgf_pkg::S_COPY && !kind_q && !dir_q && slot_q != 4'h0
      |=> gain_tbl[$past(cnt_q)] == $past(nv_g))
      else $error("gain load wrong");
   AST_PASS_THROUGH: assert property (@(posedge sys_clk) disable iff (!rst_b) // R13
      in_fire && !pix_out_valid && ctrl_q[1:0] == 2'h0
      |=> pix_out_valid && pix_out_data == $past(pix_in_data))
      else $error("pixel not passed through");
   AST_ZERO_MAP: assert property (@(posedge sys_clk) disable iff (!rst_b) // R19
      in_fire && ctrl_q[`PGF_B_MAP_EN] && interp == 8'h00 |-> corr == `PGF_PIX_MAX)
      else $error("zero map level not saturated");
   AST_NODE_INTERP: assert property (@(posedge sys_clk) disable iff (!rst_b) // R11
      in_fire && px[1:0] == 2'h0 && py[1:0] == 2'h0 |-> interp == na)
      else $error("interpolation wrong at node");
   AST_MAP_GEN: assert property (@(posedge sys_clk) disable iff (!rst_b) // R09
      st_q == pgf_pkg::S_GRUN && kind_q && in_fire && last_px
      |=> st_q == pgf_pkg::S_IDLE && map_valid_q)
      else $error("map generate did not finish");
endmodule
`default_nettype wire

// >>> verif/pgf_grabber.sv
// Frame grabber model that takes corrected pixels and stalls now and then.
`default_nettype none
module pgf_grabber (
   input  wire logic sys_clk,
   input  wire logic rst_b,
   input  wire logic pix_out_valid,
   output logic      pix_out_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] phase_q;
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         phase_q <= 3'h0;
      end else begin
         phase_q <= phase_q + 3'h1;
      end
   end
   // captures every frame
   // Two stalled cycles in eight let back-to-back input fill the FIFO.
   assign pix_out_ready = (phase_q < 3'h6);
endmodule
`default_nettype wire

// >>> verif/pgf_top_tb.sv
// Self-checking bench of the pixel gain and flat-field correction stage.
`default_nettype none
`include "pgf_consts.svh"
module pgf_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic        awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic [7:0]  araddr = 8'h00;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        pix_in_valid = 1'b0;
   logic [7:0]  pix_in_data = 8'h00;
   logic        pix_in_sof = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic        pix_in_ready, pix_out_valid, pix_out_ready, pix_out_sof;
   logic [7:0]  pix_out_data;
   int          failures = 0;
   int          checks_done = 0;
   int          cyc = 0;
   int          map_div = 0;
   integer      seed = 32'hC18B925C;
   logic        saw_full = 1'b0;
   logic [9:0]  expq[$];
   logic [7:0]  gain_tab[256];
   logic [7:0]  gen_tab[256];

   always #4 sys_clk = ~sys_clk;

   pgf_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready), .pix_in_data(pix_in_data),
      .pix_in_sof(pix_in_sof), .pix_out_valid(pix_out_valid), .pix_out_ready(pix_out_ready),
      .pix_out_data(pix_out_data), .pix_out_sof(pix_out_sof));

   pgf_grabber grabber (.sys_clk(sys_clk), .rst_b(rst_b), .pix_out_valid(pix_out_valid),
      .pix_out_ready(pix_out_ready));

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         failures++;
         $display("[FAIL] %0t seen %h want %h", $time, seen, want);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] want);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (!aw_done && awready === 1'b1) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready === 1'b1) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end while (bvalid !== 1'b1);
      check(bresp, want);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_done;
      ar_done = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (!ar_done && arready === 1'b1) begin
            ar_done = 1'b1;
            arvalid <= 1'b0;
         end
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] wd, input logic [1:0] wr_);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      check(d, wd);
      check(r, wr_);
   endtask

   task automatic cmd(input logic [31:0] c);
      logic [31:0] s;
      logic [1:0]  r;
      wr(`PGF_A_CMD, c, `PGF_RESP_OK);
      do begin
         rd(`PGF_A_STAT, s, r);
      end while (s[0] !== 1'b0);
   endtask

   function automatic logic [7:0] exp_pix(input logic [7:0] raw, input logic [7:0] g);
      int v;
      // A negative divisor stands for an all-zero map, which saturates every pixel.
      if (map_div < 0) return 8'hFF;
      v = (int'(raw) * int'(g)) >> 7;
      if (v > 255) v = 255;
      if (map_div != 0) begin
         v = v * int'(`PGF_TGT_RST) / map_div;
         if (v > 255) v = 255;
      end
      return 8'(v);
   endfunction

   // Mode 0 expects corrected pixels, 1 feeds calibration levels, 2 a flat 200, 3 a flat 0.
   task automatic frame(input int mode);
      logic [7:0] raw;
      for (int i = 0; i < 256; i++) begin
         raw = (mode == 2) ? 8'hC8 : (mode == 3) ? 8'h00
             : (mode == 1) ? 8'(150 + $unsigned($random(seed)) % 51) : 8'($random(seed));
         if (mode == 1) begin
            gen_tab[i] = 8'((int'(`PGF_TGT_RST) * 128 / int'(raw) > 255) ? 255
                            : int'(`PGF_TGT_RST) * 128 / int'(raw));
         end
         expq.push_back({mode != 0, i == 0, exp_pix(raw, gain_tab[i])});
         pix_in_valid <= 1'b1;
         pix_in_data <= raw;
         pix_in_sof <= (i == 0);
         do begin
            @(posedge sys_clk);
            if (pix_in_ready === 1'b0) saw_full = 1'b1;
         end while (pix_in_ready !== 1'b1);
      end
      pix_in_valid <= 1'b0;
      while (expq.size() != 0) @(posedge sys_clk);
      $display("frame mode %0d done", mode);
   endtask

   task automatic set_unity();
      for (int i = 0; i < 256; i++) gain_tab[i] = `PGF_UNITY;
   endtask

   always @(posedge sys_clk) begin
      if (pix_out_valid === 1'b1 && pix_out_ready === 1'b1) begin
         if (expq.size() == 0) begin
            check(32'h1, 32'h0);
         end else if (expq[0][9]) begin
            check(pix_out_sof, expq.pop_front() >> 8 & 10'h1);
         end else begin
            check({pix_out_sof, pix_out_data}, 9'(expq.pop_front()));
         end
      end
   end

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 60000) begin
         failures++;
         end_sim();
      end
   end

   initial begin
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      rd_chk(`PGF_A_CTRL, `PGF_CTRL_RST, `PGF_RESP_OK);
      rd_chk(`PGF_A_TGT, `PGF_TGT_RST, `PGF_RESP_OK);
      rd_chk(`PGF_A_STAT, 32'h0, `PGF_RESP_OK);
      rd_chk(8'h40, 32'h0, `PGF_RESP_ERR);
      wr(8'h40, 32'h0, `PGF_RESP_ERR);
      set_unity();
      wr(`PGF_A_CTRL, 32'h00, `PGF_RESP_OK);
      frame(0);
      check(saw_full, 1'b1);
      wr(`PGF_A_CTRL, 32'h03, `PGF_RESP_OK);
      map_div = 255;
      frame(0);
      wr(`PGF_A_CTRL, 32'h01, `PGF_RESP_OK);
      map_div = 0;
      // raw levels stand for dark-corrected pixels
      wr(`PGF_A_CMD, 32'h01, `PGF_RESP_OK);
      frame(1);
      cmd(32'h0);
      gain_tab = gen_tab;
      frame(0);
      cmd(32'h02);
      rd_chk(`PGF_A_STAT, 32'h2, `PGF_RESP_OK);
      wr(`PGF_A_STAT, 32'h2, `PGF_RESP_OK);
      wr(`PGF_A_CTRL, 32'h09, `PGF_RESP_OK);
      cmd(32'h02);
      rd_chk(`PGF_A_STAT, 32'h0, `PGF_RESP_OK);
      wr(`PGF_A_CTRL, 32'h01, `PGF_RESP_OK);
      cmd(32'h04);
      set_unity();
      frame(0);
      wr(`PGF_A_CTRL, 32'h09, `PGF_RESP_OK);
      cmd(32'h04);
      gain_tab = gen_tab;
      frame(0);
      $display("gain tests done");
      wr(`PGF_A_CTRL, 32'hF1, `PGF_RESP_OK);
      wr(`PGF_A_CMD, 32'h08, `PGF_RESP_OK);
      frame(2);
      cmd(32'h0);
      rd_chk(`PGF_A_STAT, 32'h4, `PGF_RESP_OK);
      cmd(32'h10);
      wr(`PGF_A_CTRL, 32'hF3, `PGF_RESP_OK);
      map_div = 200;
      frame(0);
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      rd_chk(`PGF_A_STAT, 32'h0, `PGF_RESP_OK);
      wr(`PGF_A_CTRL, 32'hF3, `PGF_RESP_OK);
      set_unity();
      map_div = 255;
      frame(0);
      cmd(32'h20);
      map_div = 200;
      frame(0);
      wr(`PGF_A_CMD, 32'h08, `PGF_RESP_OK);
      frame(3);
      cmd(32'h0);
      map_div = -1;
      frame(0);
      cmd(32'h20);
      map_div = 200;
      frame(0);
      $display("map tests done");
      end_sim();
   end
endmodule
`default_nettype wire
